//--- csm_consts.svh
// Constants for the configuration startup and reload sequencer
`ifndef CSM_CONSTS_SVH
`define CSM_CONSTS_SVH

// ==================================================================
// Clock and timing
`define CSM_CLK_MHZ        100
`define CSM_TRIG_LOW_NS    300
`define CSM_TRIG_CYC       ((`CSM_TRIG_LOW_NS*`CSM_CLK_MHZ+999)/1000)
`define CSM_PROG_LOW_NS    500
`define CSM_PROG_CYC       ((`CSM_PROG_LOW_NS*`CSM_CLK_MHZ+999)/1000)
`define CSM_CLEAR_CYC      64

// ==================================================================
// Option encodings and defaults
`define CSM_PHASE_KEEP     3'h0
`define CSM_PHASE_DONE     3'h7
`define CSM_LOCK_NO_LOCK_WAIT    3'h7
`define CSM_DEF_DONE_PH    3'h4
`define CSM_DEF_GWE_PH     3'h6
`define CSM_DEF_GTS_PH     3'h5
`define CSM_LAST_PHASE     3'h7
`define CSM_RATE_LOWEST    3'h0
`define CSM_RATE_TOP       3'h5
`define CSM_USER_ID_RST    32'hFFFFFFFF
`define CSM_SEC_NONE       2'h0
`define CSM_SEC_LEVEL2     2'h2
`define CSM_CLKSEL_CFG     2'h0
`define CSM_CLKSEL_APP     2'h1
`define CSM_CLKSEL_JTAG    2'h2

`endif

//--- csm_pkg.sv
// Types shared by the startup sequencer files
package csm_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    CSM_CLEAR,
    CSM_LOAD,
    CSM_STARTUP,
    CSM_USER,
    CSM_ERROR
  } csm_state_t;

  // Options delivered with the configuration image
  typedef struct packed {
    logic [2:0]  oscillator_rate_option;
    logic [1:0]  sequencer_clock_select;
    logic [2:0]  done_phase_select;
    logic [2:0]  write_enable_phase_select;
    logic [2:0]  io_release_phase_select;
    logic [2:0]  lock_wait_phase_select;
    logic        done_active_drive;
    logic        done_input_pipeline;
    logic        crc_check_en;
    logic [1:0]  security_level;
    logic        persist;
    logic        reload_en;
    logic [31:0] user_identifier;
  } csm_opt_t;

  // Flash control outputs
  typedef struct packed {
    logic [2:0] flash_ctrl_low;
    logic       flash_ctrl_high;
  } csm_flash_t;

endpackage

//--- csm_rate_div.sv
// Configuration clock rate divider producing a one-cycle enable
`timescale 1ns/100ps
`include "csm_consts.svh"

module csm_rate_div
  import csm_pkg::*;
(
  input  wire logic       sys_clk,  // System clock
  input  wire logic       rst,      // Async reset
  input  wire logic [2:0] rate,     // Rate code, 0 lowest
  output logic            tick_ff   // One-cycle config clock enable
);

  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;
  logic       nxt_tick;

  // Divisors for 1, 3, 6, 12, 25, 50 MHz from the system clock
  function automatic logic [6:0] div_of(input logic [2:0] r);
    case (r)
      3'h1:    div_of = 7'h21;
      3'h2:    div_of = 7'h10;
      3'h3:    div_of = 7'h08;
      3'h4:    div_of = 7'h04;
      3'h5:    div_of = 7'h02;
      default: div_of = 7'h64;
    endcase
  endfunction

  // ==================================================================
  // Counter next value
  always_comb begin
    nxt_cnt  = cnt_ff + 7'h01;
    nxt_tick = 1'b0;
    if (cnt_ff >= div_of(rate) - 7'h01) begin
      nxt_cnt  = 7'h00;
      nxt_tick = 1'b1;
    end
  end

  // Counter registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= 7'h00;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  // Enable always arrives within the slowest divisor
  property p_tick_period;
    @(posedge sys_clk) disable iff (rst)
      tick_ff |-> ##[1:100] tick_ff;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("config clock enable missing");

endmodule

//--- csm_startup.sv
// Configuration completion, startup sequencer and reload trigger
// Functional notes
// - Qualified trigger release reloads from opposite end
// - Reload off by default, parallel flash single device
// - Reload drives config pins, no program pulse
// - Program request overrides reload, uses mode pin end
// - Oscillator starts lowest, then loaded rate
// - Startup clock: config, application or JTAG clock
// - Done release phase selectable, default four
// - Write enable phase selectable, default six
// - Write enable option waits for done high
// - I/O release phase selectable, default five
// - I/O release option waits for done high
// - Keep setting retains previous write enable and I/O release phase choice
// - Optional stall at phase until clock managers lock
// - Done released to pull-up or driven high
// - Done pipeline releases on next startup edge
// - 32-bit user identifier, default all ones
// - Security levels gate readback and partial reconfig
// - CRC error holds init low, done low
// - Persist keeps parallel config pins reserved
// - Done stays low until configuration succeeds
`timescale 1ns/100ps
`include "csm_consts.svh"

module csm_startup
  import csm_pkg::*;
#(
  parameter int CMGR_N    = 4,               // Clock manager count
  parameter int CLEAR_CYC = `CSM_CLEAR_CYC   // Memory clear cycles
)(
  input  wire logic              sys_clk,            // System clock
  input  wire logic              rst,                // Async reset
  input  wire logic              program_request_n,  // Program pin
  input  wire logic              mode_pin_zero,      // Mode pin, end sel
  input  wire logic              parallel_flash_mode,// Flash mode pins
  input  wire logic              single_device,      // No daisy chain
  input  wire logic              reload_trigger,     // App reload pulse
  input  wire logic              app_clk,            // App startup clk
  input  wire logic              jtag_clk,           // JTAG test clock
  input  wire logic              done_i,             // Done pin level
  input  wire logic [CMGR_N-1:0] cmgr_locked,        // Manager locks
  input  wire logic [CMGR_N-1:0] cmgr_wait,          // Managers to wait
  input  wire logic              load_complete,      // Image loaded
  input  wire logic              crc_error,          // Image CRC failed
  input  wire csm_opt_t          opt_in,             // Image options
  output logic                   done_o_ff,          // Done pin drive
  output logic                   done_oe_ff,         // Done pin enable
  output logic                   init_o_ff,          // Init pin drive
  output logic                   init_oe_ff,         // Init pin enable
  output logic                   global_write_enable,// Write enable
  output logic                   global_three_state, // I/O hold
  output logic                   fetch_start_ff,     // Start flash read
  output logic                   fetch_high_end_ff,  // Read high end
  output logic                   cfg_pins_oe_ff,     // Drive cfg pins
  output csm_flash_t             flash_ff,           // Flash controls
  output logic [2:0]             osc_rate_ff,        // Oscillator rate
  output logic [31:0]            user_identifier,    // JTAG user id
  output logic                   readback_en_ff,     // Readback allowed
  output logic                   partial_en_ff,      // Partial reconfig
  output logic                   port_reserved_ff    // Cfg port kept
);

  localparam logic [7:0] TRIG_CYC = 8'(`CSM_TRIG_CYC);
  localparam logic [7:0] PROG_CYC = 8'(`CSM_PROG_CYC);
  localparam logic [7:0] CLR_CYC  = 8'(CLEAR_CYC);

  // ==================================================================
  // Pin synchronisers, two flops each
  logic [6:0] s1_ff, s2_ff;
  logic       app_d_ff, jtag_d_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_ff     <= 7'h7F;
      s2_ff     <= 7'h7F;
      app_d_ff  <= 1'b1;
      jtag_d_ff <= 1'b1;
    end else begin
      s1_ff     <= {program_request_n, mode_pin_zero, reload_trigger,
                    app_clk, jtag_clk, done_i, parallel_flash_mode};
      s2_ff     <= s1_ff;
      app_d_ff  <= s2_ff[3];
      jtag_d_ff <= s2_ff[2];
    end
  end
  logic [CMGR_N-1:0] lk1_ff, lk2_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lk1_ff <= '0;
      lk2_ff <= '0;
    end else begin
      lk1_ff <= cmgr_locked;
      lk2_ff <= lk1_ff;
    end
  end

  logic prog_s, mode_s, trig_s, done_s, pflash_s;
  assign prog_s   = s2_ff[6];
  assign mode_s   = s2_ff[5];
  assign trig_s   = s2_ff[4];
  assign done_s   = s2_ff[1];
  assign pflash_s = s2_ff[0];

  // ==================================================================
  // Startup clock selection
  logic cfg_tick, stup_en;
  csm_rate_div u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .rate    (osc_rate_ff),
    .tick_ff (cfg_tick)
  );
  csm_opt_t opt_ff, nxt_opt;
  always_comb begin
    unique case (opt_ff.sequencer_clock_select)
      `CSM_CLKSEL_APP:  stup_en = s2_ff[3] & ~app_d_ff;
      `CSM_CLKSEL_JTAG: stup_en = s2_ff[2] & ~jtag_d_ff;
      default:          stup_en = cfg_tick;
    endcase
  end

  // Phase reached test for 1..6 selections
  function automatic logic at_phase(input logic [2:0] sel,
                                    input logic [2:0] ph);
    at_phase = (sel != `CSM_PHASE_KEEP) && (sel != `CSM_PHASE_DONE)
               && (ph >= sel);
  endfunction

  // ==================================================================
  // Main sequencer state
  csm_state_t state_ff, nxt_state;
  logic [2:0] phase_ff, nxt_phase;
  logic [7:0] cnt_ff, nxt_cnt, prog_cnt_ff, nxt_prog_cnt;
  logic [7:0] trig_cnt_ff, nxt_trig_cnt;
  logic       trig_prev_ff, prog_prev_ff, reload_ff, nxt_reload;
  logic       gwe_ff, nxt_gwe, gts_ff, nxt_gts, rel_ff, nxt_rel;
  logic       pipe_ff, nxt_pipe, err_ff, nxt_err, end_ff, nxt_end;
  logic       nxt_fetch;
  logic [2:0] nxt_rate;
  logic       done_seen, lock_ok, trig_ok, prog_ok, adv;

  assign done_seen = opt_ff.done_input_pipeline ? pipe_ff : done_s;
  assign lock_ok   = &(lk2_ff | ~cmgr_wait);
  assign trig_ok   = trig_s & ~trig_prev_ff & (trig_cnt_ff >= TRIG_CYC);
  assign prog_ok   = prog_s & ~prog_prev_ff & (prog_cnt_ff >= PROG_CYC);

  // Next values of the sequencer
  always_comb begin
    nxt_state    = state_ff;
    nxt_phase    = phase_ff;
    nxt_cnt      = cnt_ff;
    nxt_opt      = opt_ff;
    nxt_gwe      = gwe_ff;
    nxt_gts      = gts_ff;
    nxt_rel      = rel_ff;
    nxt_pipe     = pipe_ff;
    nxt_err      = err_ff;
    nxt_end      = end_ff;
    nxt_reload   = reload_ff;
    nxt_fetch    = 1'b0;
    nxt_rate     = osc_rate_ff;
    nxt_prog_cnt = prog_s ? 8'h00 :
                   (prog_cnt_ff == 8'hFF ? prog_cnt_ff : prog_cnt_ff + 8'h01);
    nxt_trig_cnt = trig_s ? 8'h00 :
                   (trig_cnt_ff == 8'hFF ? trig_cnt_ff : trig_cnt_ff + 8'h01);
    adv          = 1'b0;
    if (prog_ok) begin
      nxt_state  = CSM_CLEAR;
      nxt_cnt    = 8'h00;
      nxt_reload = 1'b0;
      nxt_err    = 1'b0;
    end else if (!prog_s) begin
      nxt_state  = CSM_CLEAR; // Held in clear while pin stays low
      nxt_cnt    = 8'h00;
      nxt_reload = 1'b0;
    end else begin
      unique case (state_ff)
        CSM_CLEAR: begin
          nxt_cnt = cnt_ff + 8'h01;
          if (cnt_ff >= CLR_CYC) begin
            nxt_state = CSM_LOAD;
            nxt_fetch = 1'b1;
            if (!reload_ff)
              nxt_end = mode_s;
          end
        end
        CSM_LOAD: begin
          if (crc_error && opt_in.crc_check_en) begin
            nxt_state = CSM_ERROR;
            nxt_err   = 1'b1;
          end else if (load_complete) begin
            nxt_opt = opt_in;
            if (opt_in.write_enable_phase_select == `CSM_PHASE_KEEP)
              nxt_opt.write_enable_phase_select =
                opt_ff.write_enable_phase_select;
            if (opt_in.io_release_phase_select == `CSM_PHASE_KEEP)
              nxt_opt.io_release_phase_select =
                opt_ff.io_release_phase_select;
            nxt_rate  = (opt_in.oscillator_rate_option > `CSM_RATE_TOP) ?
                        `CSM_RATE_LOWEST : opt_in.oscillator_rate_option;
            nxt_state = CSM_STARTUP;
            nxt_phase = 3'h0;
          end
        end
        CSM_STARTUP: begin
          if (stup_en) begin
            nxt_pipe = done_s;
            if (!(phase_ff == opt_ff.lock_wait_phase_select &&
                  opt_ff.lock_wait_phase_select != `CSM_LOCK_NO_LOCK_WAIT &&
                  !lock_ok))
              adv = 1'b1;
            if (at_phase(opt_ff.done_phase_select, phase_ff))
              nxt_rel = 1'b1;
            if (at_phase(opt_ff.write_enable_phase_select, phase_ff) ||
                (opt_ff.write_enable_phase_select == `CSM_PHASE_DONE &&
                 done_seen))
              nxt_gwe = 1'b1;
            if (at_phase(opt_ff.io_release_phase_select, phase_ff) ||
                (opt_ff.io_release_phase_select == `CSM_PHASE_DONE &&
                 done_seen))
              nxt_gts = 1'b0;
            if (adv && phase_ff != `CSM_LAST_PHASE)
              nxt_phase = phase_ff + 3'h1;
            else if (adv && gwe_ff && !gts_ff && rel_ff)
              nxt_state = CSM_USER;
          end
        end
        CSM_USER: begin
          if (trig_ok && opt_ff.reload_en && pflash_s &&
              single_device) begin
            nxt_state  = CSM_CLEAR;
            nxt_cnt    = 8'h00;
            nxt_reload = 1'b1;
            nxt_end    = ~end_ff;
          end
        end
        CSM_ERROR: nxt_state = CSM_ERROR;
        default:   nxt_state = CSM_CLEAR;
      endcase
    end
    if (nxt_state == CSM_CLEAR) begin
      nxt_gwe  = 1'b0;
      nxt_gts  = 1'b1;
      nxt_rel  = 1'b0;
      nxt_pipe = 1'b0;
      nxt_rate = `CSM_RATE_LOWEST;
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff     <= CSM_CLEAR;
      phase_ff     <= 3'h0;
      cnt_ff       <= 8'h00;
      prog_cnt_ff  <= 8'h00;
      trig_cnt_ff  <= 8'h00;
      trig_prev_ff <= 1'b1;
      prog_prev_ff <= 1'b1;
      opt_ff       <= '{oscillator_rate_option: `CSM_RATE_LOWEST,
                        sequencer_clock_select: `CSM_CLKSEL_CFG,
                        done_phase_select: `CSM_DEF_DONE_PH,
                        write_enable_phase_select: `CSM_DEF_GWE_PH,
                        io_release_phase_select: `CSM_DEF_GTS_PH,
                        lock_wait_phase_select: `CSM_LOCK_NO_LOCK_WAIT,
                        done_active_drive: 1'b0,
                        done_input_pipeline: 1'b0,
                        crc_check_en: 1'b1,
                        security_level: `CSM_SEC_NONE,
                        persist: 1'b0, reload_en: 1'b0,
                        user_identifier: `CSM_USER_ID_RST};
      gwe_ff       <= 1'b0;
      gts_ff       <= 1'b1;
      rel_ff       <= 1'b0;
      pipe_ff      <= 1'b0;
      err_ff       <= 1'b0;
      end_ff       <= 1'b0;
      reload_ff    <= 1'b0;
      osc_rate_ff  <= `CSM_RATE_LOWEST;
      fetch_start_ff <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      phase_ff     <= nxt_phase;
      cnt_ff       <= nxt_cnt;
      prog_cnt_ff  <= nxt_prog_cnt;
      trig_cnt_ff  <= nxt_trig_cnt;
      trig_prev_ff <= trig_s;
      prog_prev_ff <= prog_s;
      opt_ff       <= nxt_opt;
      gwe_ff       <= nxt_gwe;
      gts_ff       <= nxt_gts;
      rel_ff       <= nxt_rel;
      pipe_ff      <= nxt_pipe;
      err_ff       <= nxt_err;
      end_ff       <= nxt_end;
      reload_ff    <= nxt_reload;
      osc_rate_ff  <= nxt_rate;
      fetch_start_ff <= nxt_fetch;
    end
  end
  assign global_write_enable = gwe_ff;
  assign global_three_state  = gts_ff;
  assign user_identifier     = opt_ff.user_identifier;

  // ==================================================================
  // Pin drivers and access controls
  logic       nxt_done_o, nxt_done_oe, nxt_init_oe, nxt_pins_oe;
  logic       nxt_rb, nxt_pr, nxt_res;
  csm_flash_t nxt_flash;
  always_comb begin
    nxt_done_o  = rel_ff & opt_ff.done_active_drive;
    nxt_done_oe = ~rel_ff | opt_ff.done_active_drive;
    nxt_init_oe = (state_ff == CSM_CLEAR) | err_ff;
    nxt_pins_oe = (state_ff == CSM_LOAD);
    if (nxt_pins_oe)
      nxt_flash = '{flash_ctrl_low: 3'h0, flash_ctrl_high: 1'b1};
    else
      nxt_flash = '{flash_ctrl_low: 3'h7, flash_ctrl_high: 1'b0};
    nxt_rb      = (opt_ff.security_level == `CSM_SEC_NONE);
    nxt_pr      = (opt_ff.security_level != `CSM_SEC_LEVEL2) &
                  opt_ff.persist;
    nxt_res     = opt_ff.persist & (state_ff == CSM_USER);
  end

  // Pin driver registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done_o_ff         <= 1'b0;
      done_oe_ff        <= 1'b1;
      init_o_ff         <= 1'b0;
      init_oe_ff        <= 1'b1;
      cfg_pins_oe_ff    <= 1'b0;
      flash_ff          <= '{flash_ctrl_low: 3'h7, flash_ctrl_high: 1'b0};
      fetch_high_end_ff <= 1'b0;
      readback_en_ff    <= 1'b0;
      partial_en_ff     <= 1'b0;
      port_reserved_ff  <= 1'b0;
    end else begin
      done_o_ff         <= nxt_done_o;
      done_oe_ff        <= nxt_done_oe;
      init_o_ff         <= 1'b0;
      init_oe_ff        <= nxt_init_oe;
      cfg_pins_oe_ff    <= nxt_pins_oe;
      flash_ff          <= nxt_flash;
      fetch_high_end_ff <= end_ff;
      readback_en_ff    <= nxt_rb;
      partial_en_ff     <= nxt_pr;
      port_reserved_ff  <= nxt_res;
    end
  end

  // ==================================================================
  // Checks
  property p_reload_flip;
    @(posedge sys_clk) disable iff (rst)
      (state_ff == CSM_USER && prog_s && trig_ok && opt_ff.reload_en &&
       pflash_s && single_device) |=> (end_ff != $past(end_ff));
  endproperty
  a_reload_flip: assert property (p_reload_flip)
    else $error("reload did not flip flash end");

  property p_reload_gated;
    @(posedge sys_clk) disable iff (rst)
      (state_ff == CSM_USER && !opt_ff.reload_en && prog_s) |=>
        state_ff == CSM_USER;
  endproperty
  a_reload_gated: assert property (p_reload_gated)
    else $error("reload taken while disabled");

  property p_prog_wins;
    @(posedge sys_clk) disable iff (rst)
      prog_ok |=> (state_ff == CSM_CLEAR && !reload_ff);
  endproperty
  a_prog_wins: assert property (p_prog_wins)
    else $error("program request did not restart");

  property p_done_low;
    @(posedge sys_clk) disable iff (rst)
      (state_ff == CSM_LOAD) |=> ##1 (done_oe_ff && !done_o_ff);
  endproperty
  a_done_low: assert property (p_done_low)
    else $error("done not held low while loading");

  property p_crc_err;
    @(posedge sys_clk) disable iff (rst)
      (state_ff == CSM_LOAD && prog_s && crc_error && opt_in.crc_check_en)
        |=> ##1 (init_oe_ff && !rel_ff) [*3];
  endproperty
  a_crc_err: assert property (p_crc_err)
    else $error("crc error not reported");

  property p_one_step;
    @(posedge sys_clk) disable iff (rst)
      (state_ff == CSM_STARTUP && $past(state_ff) == CSM_STARTUP &&
       $changed(phase_ff)) |->
        (phase_ff == $past(phase_ff) + 3'h1);
  endproperty
  a_one_step: assert property (p_one_step)
    else $error("phase skipped");

  property p_lock_stall;
    @(posedge sys_clk) disable iff (rst)
      (state_ff == CSM_STARTUP && stup_en && !lock_ok &&
       opt_ff.lock_wait_phase_select != `CSM_LOCK_NO_LOCK_WAIT &&
       phase_ff == opt_ff.lock_wait_phase_select && prog_s) |=>
        $stable(phase_ff);
  endproperty
  a_lock_stall: assert property (p_lock_stall)
    else $error("phase advanced without lock");

  property p_rate_low;
    @(posedge sys_clk) disable iff (rst)
      (state_ff == CSM_CLEAR) |=> osc_rate_ff == `CSM_RATE_LOWEST;
  endproperty
  a_rate_low: assert property (p_rate_low)
    else $error("oscillator not at lowest rate");

  property p_gwe_done;
    @(posedge sys_clk) disable iff (rst)
      ($rose(gwe_ff) && opt_ff.write_enable_phase_select ==
       `CSM_PHASE_DONE) |-> $past(done_seen);
  endproperty
  a_gwe_done: assert property (p_gwe_done)
    else $error("write enable before done seen");

  c_reload: cover property (@(posedge sys_clk) disable iff (rst)
    state_ff == CSM_USER ##1 state_ff == CSM_CLEAR && reload_ff);
  c_user: cover property (@(posedge sys_clk) disable iff (rst)
    state_ff == CSM_STARTUP ##1 state_ff == CSM_USER);
  c_error: cover property (@(posedge sys_clk) disable iff (rst)
    state_ff == CSM_LOAD ##1 state_ff == CSM_ERROR);

endmodule

//--- csm_flash_model.sv
// Flash and application side model for the startup sequencer
`timescale 1ns/100ps

module csm_flash_model (
  input  wire logic sys_clk,     // System clock
  input  wire logic rst,         // Async reset
  input  wire logic fetch_start, // Image read begins
  input  wire logic bad_image,   // Answer with a CRC failure
  input  wire logic done_o,      // Done pin drive
  input  wire logic done_oe,     // Done pin enable
  output logic      load_ff,     // Image loaded pulse
  output logic      crc_ff,      // CRC failure pulse
  output wire logic done_pin     // Done wire level
);
  // ======================================
  // Model state
  int cnt_ff;

  // External pull-up holds the released done wire high
  assign done_pin = done_oe ? done_o : 1'b1;

  // Image read lasts a fixed span; model never drives config pins
  always_ff @(posedge sys_clk or posedge rst) begin
    load_ff <= 1'b0;
    crc_ff  <= 1'b0;
    if (rst)
      cnt_ff <= 0;
    else if (fetch_start)
      cnt_ff <= 12;
    else if (cnt_ff > 0) begin
      cnt_ff <= cnt_ff - 1;
      if (cnt_ff == 1) begin
        load_ff <= !bad_image;
        crc_ff  <= bad_image;
      end
    end
  end
endmodule

//--- csm_startup_test.sv
// Testbench for the configuration startup and reload sequencer
`timescale 1ns/100ps

module csm_startup_test;
  import csm_pkg::*;
  // ======================================
  // Stimulus and observed signals
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        program_request_n = 1'b1;
  logic        mode_pin_zero = 1'b0;
  logic        parallel_flash_mode = 1'b1;
  logic        reload_trigger = 1'b1;
  logic        app_clk = 1'b0;
  logic        bad = 1'b0;
  logic [3:0]  cmgr_locked = 4'h0;
  logic [3:0]  cmgr_wait = 4'h1;
  logic        done_i, load_complete, crc_error, done_o_ff, done_oe_ff;
  logic        init_o_ff, init_oe_ff, global_write_enable;
  logic        global_three_state, fetch_start_ff, fetch_high_end_ff;
  logic        cfg_pins_oe_ff, readback_en_ff, partial_en_ff;
  logic        port_reserved_ff;
  logic [2:0]  osc_rate_ff;
  logic [31:0] user_identifier;
  csm_flash_t  flash_ff;
  csm_opt_t    opt_in;
  int          n_errors = 0;
  int          n_tests = 0;

  csm_startup #(.CMGR_N(4), .CLEAR_CYC(4)) u_dut (
    .sys_clk, .rst, .program_request_n, .mode_pin_zero,
    .parallel_flash_mode, .single_device(1'b1), .reload_trigger,
    .app_clk, .jtag_clk(1'b0), .done_i, .cmgr_locked, .cmgr_wait,
    .load_complete, .crc_error, .opt_in, .done_o_ff, .done_oe_ff,
    .init_o_ff, .init_oe_ff, .global_write_enable, .global_three_state,
    .fetch_start_ff, .fetch_high_end_ff, .cfg_pins_oe_ff, .flash_ff,
    .osc_rate_ff, .user_identifier, .readback_en_ff, .partial_en_ff,
    .port_reserved_ff);

  csm_flash_model u_flash (
    .sys_clk, .rst, .fetch_start(fetch_start_ff), .bad_image(bad),
    .done_o(done_o_ff), .done_oe(done_oe_ff), .load_ff(load_complete),
    .crc_ff(crc_error), .done_pin(done_i));

  // Clock, 10 ns period
  always #5 sys_clk = ~sys_clk;

  // Application startup clock, rising every second cycle
  always @(posedge sys_clk) app_clk <= ~app_clk;

  // ======================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Waits for image fetch (0) or write enable (1), bounded
  // Returns one cycle later, once the registered pin outputs follow
  task automatic wait_for(input int sel, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if (sel == 0 && fetch_start_ff === 1'b1)
        break;
      if (sel == 1 && global_write_enable === 1'b1)
        break;
      @(negedge sys_clk);
    end
    if (i == lim) begin
      n_errors++;
      $display("BAD %0t wait limit", $time);
    end
    @(negedge sys_clk);
  endtask

  // Low pulse of n cycles on program pin (1) or reload trigger (0)
  task automatic pulse(input bit prog, input int n);
    @(posedge sys_clk);
    if (prog)
      program_request_n <= 1'b0;
    else
      reload_trigger <= 1'b0;
    repeat (n) @(posedge sys_clk);
    program_request_n <= 1'b1;
    reload_trigger <= 1'b1;
    @(negedge sys_clk);
  endtask

  task automatic wrap_up;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ======================================
  // Scenarios
  task automatic t_reset;
    @(negedge sys_clk);
    chk({done_oe_ff, done_o_ff}, 2'h2);
    chk(global_three_state, 1'b1);
    chk(osc_rate_ff, 3'h0);
    chk(user_identifier, 32'hFFFFFFFF);
    $display("t_reset end");
  endtask

  // Boot with a lock stall at phase 3, then release the lock
  task automatic t_boot;
    wait_for(0, 100);
    chk(fetch_high_end_ff, 1'b0);
    chk(cfg_pins_oe_ff, 1'b1);
    chk(flash_ff, 4'h1);
    repeat (100) @(negedge sys_clk);
    chk(global_write_enable, 1'b0);
    chk({done_oe_ff, done_o_ff}, 2'h2);
    @(posedge sys_clk);
    cmgr_locked <= 4'hF;
    wait_for(1, 100);
    repeat (20) @(negedge sys_clk);
    chk(global_write_enable, 1'b1);
    chk(global_three_state, 1'b0);
    chk(done_oe_ff, 1'b0);
    chk(osc_rate_ff, 3'h5);
    chk(user_identifier, 32'h1234ABCD);
    chk({readback_en_ff, partial_en_ff}, 2'h1);
    chk(port_reserved_ff, 1'b1);
    $display("t_boot end");
  endtask

  // Trigger outside flash mode, then a too-short pulse: both ignored
  task automatic t_refuse;
    @(posedge sys_clk);
    parallel_flash_mode <= 1'b0;
    pulse(0, 40);
    repeat (10) @(negedge sys_clk);
    chk(global_write_enable, 1'b1);
    @(posedge sys_clk);
    parallel_flash_mode <= 1'b1;
    pulse(0, 20);
    repeat (10) @(negedge sys_clk);
    chk(global_write_enable, 1'b1);
    chk(cfg_pins_oe_ff, 1'b0);
    $display("t_refuse end");
  endtask

  // Valid reload from the far end, answered with a CRC failure
  task automatic t_reload;
    @(posedge sys_clk);
    bad <= 1'b1;
    pulse(0, 40);
    wait_for(0, 60);
    chk(fetch_high_end_ff, 1'b1);
    chk(cfg_pins_oe_ff, 1'b1);
    repeat (40) @(negedge sys_clk);
    chk({init_oe_ff, init_o_ff}, 2'h2);
    chk({done_oe_ff, done_o_ff}, 2'h2);
    chk(global_write_enable, 1'b0);
    $display("t_reload end");
  endtask

  // Program pulse recovers from the error with new options
  task automatic t_prog;
    @(posedge sys_clk);
    bad <= 1'b0;
    opt_in.done_active_drive <= 1'b1;
    opt_in.persist <= 1'b0;
    opt_in.security_level <= 2'h2;
    opt_in.sequencer_clock_select <= 2'h1;
    opt_in.write_enable_phase_select <= 3'h7;
    opt_in.done_input_pipeline <= 1'b1;
    pulse(1, 60);
    wait_for(0, 60);
    chk(fetch_high_end_ff, 1'b0);
    wait_for(1, 100);
    repeat (20) @(negedge sys_clk);
    chk({done_oe_ff, done_o_ff}, 2'h3);
    chk({readback_en_ff, partial_en_ff}, 2'h0);
    chk(port_reserved_ff, 1'b0);
    $display("t_prog end");
  endtask

  // Main sequence
  initial begin
    opt_in = '0;
    opt_in.oscillator_rate_option = 3'h5;
    opt_in.done_phase_select = 3'h4;
    opt_in.write_enable_phase_select = 3'h6;
    opt_in.io_release_phase_select = 3'h5;
    opt_in.lock_wait_phase_select = 3'h3;
    opt_in.crc_check_en = 1'b1;
    opt_in.security_level = 2'h1;
    opt_in.persist = 1'b1;
    opt_in.reload_en = 1'b1;
    opt_in.user_identifier = 32'h1234ABCD;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_boot;
    t_refuse;
    t_reload;
    t_prog;
    wrap_up;
  end

  // Watchdog: the run needs well under 2000 cycles
  initial begin
    #50000;
    n_errors++;
    wrap_up;
  end
endmodule
